// ==== include/nvc_pkg.sv ====
package nvc_pkg;
  // timing, 20 MHz system clock
  localparam int CLK_NS = 50;
  localparam int T_WRITE_NS = 50000;
  localparam int T_PAGE_NS = 2000000;
  localparam int T_ALL_NS = 4000000;
  localparam int WRITE_CYC = (T_WRITE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PAGE_CYC = (T_PAGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ALL_CYC = (T_ALL_NS + CLK_NS - 1) / CLK_NS;
  // memory geometry
  localparam int FLASH_WORDS = 64;
  localparam int PAGE_WORDS = 16;
  localparam int USER_WORDS = 8;
  localparam int N_WRITE = 2;
  localparam logic [31:0] FACT_WORD = 32'h0000_5a5a;
  // address map of the controller side
  localparam logic [3:0] FLASH_REGION = 4'h0;
  localparam logic [19:0] FACT_PAGE = 20'h10000;
  localparam logic [19:0] USER_PAGE = 20'h10001;
  localparam logic [19:0] REG_PAGE = 20'h40000;
  localparam logic [11:0] READY_OFS = 12'h400;
  localparam logic [11:0] CONFIG_OFS = 12'h504;
  localparam logic [11:0] PAGE_ERASE_OFS = 12'h508;
  localparam logic [11:0] ALL_ERASE_OFS = 12'h50c;
  localparam logic [11:0] USER_ERASE_OFS = 12'h514;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // host command registers
  localparam logic [7:0] HOST_CTRL_OFS = 8'h00;
  localparam logic [7:0] HOST_ADDR_OFS = 8'h04;
  localparam logic [7:0] HOST_WDATA_OFS = 8'h08;
  localparam logic [7:0] HOST_RDATA_OFS = 8'h0c;
  localparam logic [7:0] HOST_STATUS_OFS = 8'h10;
  localparam logic [7:0] HOST_IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] HOST_IRQ_MASK_OFS = 8'h18;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_WE_BIT = 1;
  localparam int CTRL_FETCH_BIT = 2;
  localparam int CTRL_SIZE_LSB = 4;
  localparam int CTRL_DEBUG_BIT = 8;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FAULT_BIT = 1;
  localparam int IRQ_REFUSED_BIT = 2;
  typedef enum logic [1:0] {NVC_RO = 2'h0, NVC_WEN = 2'h1, NVC_EEN = 2'h2} nvc_mode_t;
  typedef enum logic [1:0] {OP_IDLE = 2'b00, OP_WRITE = 2'b01, OP_ERASE = 2'b11} nvc_op_t;
  typedef enum logic [1:0] {ER_PAGE = 2'h0, ER_USER = 2'h1, ER_ALL = 2'h2} nvc_erase_t;
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_HALT = 2'b01, H_BUSY = 2'b11} nvc_host_st_t;
endpackage : nvc_pkg

// ==== include/nvc_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface nvc_link_if;
  logic req;
  logic we;
  logic fetch;
  logic [1:0] size;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic done;
  logic fault;
  modport dev (input req, we, fetch, size, addr, wdata, output rdata, done, fault);
  modport host (output req, we, fetch, size, addr, wdata, input rdata, done, fault);
endinterface : nvc_link_if
`default_nettype wire

// ==== rtl/nvc_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module nvc_timer #(
  parameter int W = 32
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic start_in,
  input wire logic [W-1:0] load_in,
  output logic done_out
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_q <= '0;
    end else if (start_in) begin
      cnt_q <= load_in;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  // a load of n gives done at the n-th edge after start
  assign done_out = (cnt_q == W'(1));
endmodule : nvc_timer
`default_nettype wire

// ==== rtl/nvc_device.sv ====
`timescale 1ns/1ps
`default_nettype none
module nvc_device import nvc_pkg::*; #(
  parameter int FLASH_WORDS_P = FLASH_WORDS,
  parameter int WRITE_CYC_P = WRITE_CYC,
  parameter int PAGE_CYC_P = PAGE_CYC,
  parameter int ALL_CYC_P = ALL_CYC
) (
  input wire logic clock_in,
  input wire logic reset_in,
  nvc_link_if.dev link,
  output logic [31:0] user_cfg_out
);
  localparam int FW = $clog2(FLASH_WORDS_P);
  localparam int UW = $clog2(USER_WORDS);
  localparam int PW = $clog2(PAGE_WORDS);

  logic [31:0] flash_mem [FLASH_WORDS_P];
  logic [31:0] user_mem [USER_WORDS];

  nvc_mode_t mode_q;
  nvc_op_t op_q;
  nvc_erase_t er_kind_q;
  nvc_erase_t req_kind;
  logic [FW-PW-1:0] er_page_q;
  logic tgt_user_q;
  logic [FW-1:0] tgt_idx_q;
  logic [31:0] tgt_data_q;
  logic done_q;
  logic fault_q;
  logic [31:0] rdata_q;
  logic cfg_loaded_q;
  logic is_flash;
  logic is_user;
  logic is_fact;
  logic is_reg;
  logic mem_acc;
  logic aligned;
  logic take;
  logic idle;
  logic is_erase_cmd;
  logic do_fault;
  logic do_write;
  logic do_erase;
  logic stall;
  logic do_done;
  logic tmr_start;
  logic tmr_done;
  logic write_fin;
  logic erase_fin;
  logic [31:0] tmr_load;
  logic [31:0] rd_word;
  logic [11:0] ofs;
  logic [FW-1:0] fidx;
  logic [UW-1:0] uidx;

  assign ofs = link.addr[11:0];
  assign fidx = link.addr[FW+1:2];
  assign uidx = link.addr[UW+1:2];
  assign is_flash = link.addr[31:28] == FLASH_REGION;
  assign is_user = link.addr[31:12] == USER_PAGE;
  assign is_fact = link.addr[31:12] == FACT_PAGE;
  assign is_reg = link.addr[31:12] == REG_PAGE;
  assign mem_acc = is_flash || is_user || is_fact;
  assign aligned = (link.size == SIZE_WORD) && (link.addr[1:0] == 2'h0);
  // one answer per request: wait until the previous answer is gone
  assign take = link.req && !done_q && !fault_q;
  assign idle = (op_q == OP_IDLE);
  assign is_erase_cmd = is_reg &&
      (ofs == PAGE_ERASE_OFS || ofs == ALL_ERASE_OFS || ofs == USER_ERASE_OFS);

  assign do_fault = take && link.we && mem_acc && !aligned;
  assign do_write = take && link.we && (is_flash || is_user) && aligned && idle
      && (mode_q == NVC_WEN);
  assign do_erase = take && link.we && is_erase_cmd && idle
      && (mode_q == NVC_EEN);
  // fetches and most writes wait out a running operation; data reads and bad-size memory writes, which fault at once, do not
  assign stall = !idle && (link.fetch || link.we);
  assign do_done = take && !do_fault && !do_write && !stall;

  always_comb begin
    req_kind = ER_PAGE;
    if (ofs == ALL_ERASE_OFS) begin
      req_kind = ER_ALL;
    end else if (ofs == USER_ERASE_OFS) begin
      req_kind = ER_USER;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if (is_reg && ofs == READY_OFS) begin
      rd_word = {31'h0000_0000, idle};
    end else if (is_reg && ofs == CONFIG_OFS) begin
      rd_word = {30'h0000_0000, mode_q};
    end else if (is_flash) begin
      rd_word = flash_mem[fidx];
    end else if (is_user) begin
      rd_word = user_mem[uidx];
    end else if (is_fact) begin
      rd_word = FACT_WORD;
    end
  end

  assign tmr_start = do_write || do_erase;
  assign tmr_load = do_write ? 32'(WRITE_CYC_P) :
      (req_kind == ER_ALL) ? 32'(ALL_CYC_P) : 32'(PAGE_CYC_P);
  assign write_fin = tmr_done && (op_q == OP_WRITE);
  assign erase_fin = tmr_done && (op_q == OP_ERASE);

  nvc_timer #(.W(32)) u_timer (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .start_in(tmr_start),
    .load_in(tmr_load),
    .done_out(tmr_done)
  );

  // value 3 is stored as written; neither mode is then active
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      mode_q <= NVC_RO;
    end else if (take && link.we && is_reg && idle && ofs == CONFIG_OFS) begin
      mode_q <= nvc_mode_t'(link.wdata[1:0]);
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      op_q <= OP_IDLE;
    end else begin
      unique case (op_q)
        OP_IDLE: begin
          if (do_write) begin
            op_q <= OP_WRITE;
          end else if (do_erase) begin
            op_q <= OP_ERASE;
          end
        end
        OP_WRITE, OP_ERASE: begin
          if (tmr_done) begin
            op_q <= OP_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      tgt_user_q <= 1'b0;
      tgt_idx_q <= '0;
      tgt_data_q <= 32'h0000_0000;
      er_kind_q <= ER_PAGE;
      er_page_q <= '0;
    end else if (do_write) begin
      tgt_user_q <= is_user;
      tgt_idx_q <= is_user ? FW'(uidx) : fidx;
      tgt_data_q <= link.wdata;
    end else if (do_erase) begin
      er_kind_q <= req_kind;
      er_page_q <= link.wdata[FW+1:PW+2];
    end
  end

  // the answer to a word write in write-enable mode waits for the write to finish
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      done_q <= 1'b0;
      fault_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      done_q <= do_done || write_fin;
      fault_q <= do_fault;
      if (do_done && !link.we) begin
        rdata_q <= rd_word;
      end
    end
  end

  assign link.done = done_q;
  assign link.fault = fault_q;
  assign link.rdata = rdata_q;

  // contents are nonvolatile, so the arrays carry no reset
  always_ff @(posedge clock_in) begin
    for (int i = 0; i < FLASH_WORDS_P; i++) begin
      if (erase_fin && (er_kind_q == ER_ALL || (er_kind_q == ER_PAGE
          && (i >> PW) == int'(er_page_q)))) begin
        flash_mem[i] <= 32'hffff_ffff;
      end
    end
    if (write_fin && !tgt_user_q) begin
      flash_mem[tgt_idx_q] <= flash_mem[tgt_idx_q] & tgt_data_q;
    end
  end

  always_ff @(posedge clock_in) begin
    for (int i = 0; i < USER_WORDS; i++) begin
      if (erase_fin && er_kind_q != ER_PAGE) begin
        user_mem[i] <= 32'hffff_ffff;
      end
    end
    if (write_fin && tgt_user_q) begin
      user_mem[tgt_idx_q[UW-1:0]] <= user_mem[tgt_idx_q[UW-1:0]] & tgt_data_q;
    end
  end

  // configuration word is sampled once, on the first edge after reset
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      cfg_loaded_q <= 1'b0;
      user_cfg_out <= 32'h0000_0000;
    end else if (!cfg_loaded_q) begin
      cfg_loaded_q <= 1'b1;
      user_cfg_out <= user_mem[0];
    end
  end
endmodule : nvc_device
`default_nettype wire

// ==== rtl/nvc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module nvc_host import nvc_pkg::*; #(
  parameter int N_WRITE_P = N_WRITE
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic [31:0] hrdata_out,
  output logic hresp_out,
  output logic irq_out,
  output logic halt_core_out,
  nvc_link_if.host link
);
  localparam int FW = $clog2(FLASH_WORDS);
  localparam int UW = $clog2(USER_WORDS);
  localparam int PW = $clog2(PAGE_WORDS);
  localparam int NW = FLASH_WORDS + USER_WORDS;
  localparam int CW = $clog2(N_WRITE_P + 1);
  localparam int CX = $clog2(NW);

  nvc_host_st_t st_q;
  logic [CW-1:0] cnt_q [NW];
  logic [31:0] ctrl_q, addr_q, wdata_q, rdata_q, lk_addr_q, lk_wdata_q;
  logic [2:0] irq_stat_q, irq_mask_q, irq_set, irq_clr;
  logic [1:0] cfg_q, lk_size_q;
  logic ap_wr_q, req_q, we_q, fetch_q;
  logic [7:0] ap_ofs_q;
  logic take_ap, go, g_we, is_flash, is_user, is_cfg, is_erase;
  logic mem_wr, over, bad_cfg, refuse, issue, finish;
  logic [31:0] rd_mux;
  logic [CX-1:0] cidx;
  logic [11:0] lofs;

  assign take_ap = hsel_in && htrans_in[1] && hready_in;
  assign go = ap_wr_q && ap_ofs_q == HOST_CTRL_OFS && hwdata_in[CTRL_GO_BIT];
  assign g_we = hwdata_in[CTRL_WE_BIT];
  assign lofs = addr_q[11:0];
  assign is_flash = addr_q[31:28] == FLASH_REGION;
  assign is_user = addr_q[31:12] == USER_PAGE;
  assign is_cfg = addr_q[31:12] == REG_PAGE && lofs == CONFIG_OFS;
  assign is_erase = addr_q[31:12] == REG_PAGE && (lofs == PAGE_ERASE_OFS
      || lofs == ALL_ERASE_OFS || lofs == USER_ERASE_OFS);
  assign cidx = is_user ? CX'(FLASH_WORDS + int'(addr_q[UW+1:2]))
      : CX'(addr_q[FW+1:2]);
  assign mem_wr = g_we && (is_flash || is_user);
  // refused before the write could wear the word beyond its limit
  assign over = mem_wr && cfg_q == NVC_WEN && int'(cnt_q[cidx]) >= N_WRITE_P;
  assign bad_cfg = g_we && is_cfg && wdata_q[1:0] == 2'h3;
  assign refuse = go && (st_q != H_IDLE || over || bad_cfg);
  assign issue = go && !refuse;
  assign finish = st_q == H_BUSY && (link.done || link.fault);

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr_in[7:0])
      HOST_CTRL_OFS: rd_mux = ctrl_q;
      HOST_ADDR_OFS: rd_mux = addr_q;
      HOST_WDATA_OFS: rd_mux = wdata_q;
      HOST_RDATA_OFS: rd_mux = rdata_q;
      HOST_STATUS_OFS: rd_mux = {31'h0000_0000, st_q != H_IDLE};
      HOST_IRQ_STAT_OFS: rd_mux = {29'h0000_0000, irq_stat_q};
      HOST_IRQ_MASK_OFS: rd_mux = {29'h0000_0000, irq_mask_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // zero wait states: read data is prepared in the address phase
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      ap_wr_q <= 1'b0;
      ap_ofs_q <= 8'h00;
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      ap_wr_q <= take_ap && hwrite_in;
      ap_ofs_q <= haddr_in[7:0];
      if (take_ap && !hwrite_in) begin
        hrdata_out <= rd_mux;
      end
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_q <= 32'h0000_0000;
      addr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      irq_mask_q <= 3'h0;
    end else if (ap_wr_q) begin
      if (ap_ofs_q == HOST_CTRL_OFS) ctrl_q <= hwdata_in;
      if (ap_ofs_q == HOST_ADDR_OFS) addr_q <= hwdata_in;
      if (ap_ofs_q == HOST_WDATA_OFS) wdata_q <= hwdata_in;
      if (ap_ofs_q == HOST_IRQ_MASK_OFS) irq_mask_q <= hwdata_in[2:0];
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      st_q <= H_IDLE;
      req_q <= 1'b0;
      halt_core_out <= 1'b0;
      we_q <= 1'b0;
      fetch_q <= 1'b0;
      lk_size_q <= 2'h0;
      lk_addr_q <= 32'h0000_0000;
      lk_wdata_q <= 32'h0000_0000;
    end else begin
      unique case (st_q)
        H_IDLE: begin
          if (issue) begin
            we_q <= g_we;
            fetch_q <= hwdata_in[CTRL_FETCH_BIT];
            lk_size_q <= hwdata_in[CTRL_SIZE_LSB+1:CTRL_SIZE_LSB];
            lk_addr_q <= addr_q;
            lk_wdata_q <= wdata_q;
            if (hwdata_in[CTRL_DEBUG_BIT] && g_we) begin
              st_q <= H_HALT;
              halt_core_out <= 1'b1;
            end else begin
              st_q <= H_BUSY;
              req_q <= 1'b1;
            end
          end
        end
        H_HALT: begin
          st_q <= H_BUSY;
          req_q <= 1'b1;
        end
        H_BUSY: begin
          if (finish) begin
            st_q <= H_IDLE;
            req_q <= 1'b0;
            halt_core_out <= 1'b0;
          end
        end
      endcase
    end
  end

  assign link.req = req_q;
  assign link.we = we_q;
  assign link.fetch = fetch_q;
  assign link.size = lk_size_q;
  assign link.addr = lk_addr_q;
  assign link.wdata = lk_wdata_q;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (finish && link.done && !we_q) begin
      rdata_q <= link.rdata;
    end
  end

  // mode is tracked from the configuration writes this end issues
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      cfg_q <= 2'h0;
    end else if (issue && is_cfg && g_we) begin
      cfg_q <= wdata_q[1:0];
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < NW; i++) cnt_q[i] <= '0;
    end else if (issue && mem_wr && cfg_q == NVC_WEN) begin
      cnt_q[cidx] <= cnt_q[cidx] + CW'(1);
    end else if (issue && g_we && is_erase && cfg_q == NVC_EEN) begin
      for (int i = 0; i < NW; i++) begin
        if (lofs == ALL_ERASE_OFS || (lofs == USER_ERASE_OFS && i >= FLASH_WORDS)
            || (lofs == PAGE_ERASE_OFS && i < FLASH_WORDS
            && (i >> PW) == int'(wdata_q[FW+1:PW+2]))) begin
          cnt_q[i] <= '0;
        end
      end
    end
  end

  assign irq_set = {refuse, finish && link.fault, finish && link.done};
  assign irq_clr = {3{take_ap && !hwrite_in && haddr_in[7:0] == HOST_IRQ_STAT_OFS}};

  // a new event in the clearing read's cycle survives the clear
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      irq_stat_q <= 3'h0;
      irq_out <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      irq_out <= |(irq_stat_q & irq_mask_q);
    end
  end
endmodule : nvc_host
`default_nettype wire

// ==== test/nvc_link_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module nvc_link_sva import nvc_pkg::*; #(
  parameter int WRITE_CYC_P = WRITE_CYC,
  parameter int PAGE_CYC_P = PAGE_CYC,
  parameter int ALL_CYC_P = ALL_CYC
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic req,
  input wire logic we,
  input wire logic fetch,
  input wire logic [1:0] size,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic done,
  input wire logic fault
);
  localparam int WR_A = WRITE_CYC_P - 3;
  localparam int WR_B = WRITE_CYC_P - 2;
  localparam int FETCH_MAX = ALL_CYC_P + 20;
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  logic [1:0] mode_q;
  logic [31:0] er_q;
  wire mem_w = we && (addr[31:28] == FLASH_REGION || addr[31:12] == USER_PAGE);
  wire word_ok = size == SIZE_WORD && addr[1:0] == 2'h0;
  // factory words fault on a bad size too, though no write ever lands there
  wire fact_w = we && addr[31:12] == FACT_PAGE;
  wire cfg_w = req && we && addr == {REG_PAGE, CONFIG_OFS};
  wire rdy_rd = done && !we && addr == {REG_PAGE, READY_OFS};
  wire er_w = req && we && addr[31:12] == REG_PAGE && (addr[11:0] == PAGE_ERASE_OFS ||
              addr[11:0] == ALL_ERASE_OFS || addr[11:0] == USER_ERASE_OFS);
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      mode_q <= NVC_RO;
    end else if (done && cfg_w) begin
      mode_q <= wdata[1:0];
    end
  end
  // margin of two cycles either side of the erase end, so edge slop never fires
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      er_q <= 32'h0;
    end else if (done && er_w && mode_q == NVC_EEN) begin
      er_q <= (addr[11:0] == ALL_ERASE_OFS ? ALL_CYC_P : PAGE_CYC_P) + 2;
    end else if (er_q != 32'h0) begin
      er_q <= er_q - 32'h1;
    end
  end
  sequence s_word_wr;
    $rose(req) && mem_w && word_ok && mode_q == NVC_WEN && er_q == 32'h0;
  endsequence
  sequence s_quiet;
    (!done && !fault) [*3];
  endsequence
  property p_write_time;
    s_word_wr |=> s_quiet ##[WR_A:WR_B] done;
  endproperty
  a_write_time: assert property (p_write_time) else $error("word write time wrong");
  property p_quick_ro;
    $rose(req) && mem_w && word_ok && mode_q == NVC_RO |-> ##[1:2] done;
  endproperty
  a_quick_ro: assert property (p_quick_ro) else $error("read-only write not answered");
  property p_sub_fault;
    $rose(req) && mem_w && !word_ok && mode_q == NVC_WEN && er_q == 32'h0 |-> ##[1:2] fault;
  endproperty
  a_sub_fault: assert property (p_sub_fault) else $error("sub-word write did not fault");
  property p_fault_cause;
    fault |-> $past(req) && ($past(mem_w) || $past(fact_w)) && !$past(word_ok);
  endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("fault without bad write");
  property p_excl;
    done |-> !fault ##1 !done;
  endproperty
  a_excl: assert property (p_excl) else $error("done not a lone pulse");
  property p_ready_busy;
    rdy_rd && er_q > 32'h4 |-> rdata[0] == 1'b0;
  endproperty
  a_ready_busy: assert property (p_ready_busy) else $error("ready set during erase");
  property p_ready_idle;
    rdy_rd && er_q == 32'h0 |-> rdata[0] == 1'b1;
  endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("ready clear when idle");
  property p_fetch_stall;
    done && fetch |-> er_q <= 32'h4;
  endproperty
  a_fetch_stall: assert property (p_fetch_stall) else $error("fetch served in erase");
  property p_fetch_bound;
    $rose(req) && fetch |-> ##[1:FETCH_MAX] done;
  endproperty
  a_fetch_bound: assert property (p_fetch_bound) else $error("fetch never answered");
  property p_mode_legal;
    done && cfg_w |-> wdata[1:0] != 2'h3;
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("both modes enabled");
endmodule : nvc_link_sva
`default_nettype wire

// ==== test/flash_program_erase_ctrl_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module flash_program_erase_ctrl_bench import nvc_pkg::*;;
  localparam int WR_C = 4;
  localparam int PG_C = 200;
  localparam int AL_C = 300;
  localparam logic [31:0] WR = 32'h23;
  localparam logic [31:0] RD = 32'h21;
  localparam logic [31:0] FE = 32'h25;
  localparam logic [31:0] UA = {USER_PAGE, 12'h000};
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready, irq, halt, hresp, irq_seen, halt_seen;
  logic [31:0] hrdata, ucfg, stat, rd;
  logic [31:0] bad_c [3] = '{32'h23, 32'h03, 32'h13};
  // first bad address sits in a word with writes left, so the host sends it
  logic [31:0] bad_a [3] = '{32'h1a, 32'h8, 32'h8};
  int busy_cyc;
  int error_cnt = 0;
  int cmp_count = 0;
  always #25 clock_in = ~clock_in;
  nvc_link_if link();
  nvc_host u_nvc_host (.clock_in(clock_in), .reset_in(reset_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready), .hrdata_out(hrdata),
    .hresp_out(hresp), .irq_out(irq), .halt_core_out(halt), .link(link));
  nvc_device #(.WRITE_CYC_P(WR_C), .PAGE_CYC_P(PG_C), .ALL_CYC_P(AL_C)) u_nvc_device (
    .clock_in(clock_in), .reset_in(reset_in), .link(link), .user_cfg_out(ucfg));
  nvc_link_sva #(.WRITE_CYC_P(WR_C), .PAGE_CYC_P(PG_C), .ALL_CYC_P(AL_C)) u_nvc_link_sva (
    .clock_in(clock_in), .reset_in(reset_in), .req(link.req), .we(link.we),
    .fetch(link.fetch), .size(link.size), .addr(link.addr), .wdata(link.wdata),
    .rdata(link.rdata), .done(link.done), .fault(link.fault));
  function automatic logic [31:0] ra(input logic [11:0] o);
    return {REG_PAGE, o};
  endfunction : ra
  task automatic report_and_stop();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  task automatic wait_hi();
    int n;
    n = 0;
    @(posedge clock_in);
    while (hready !== 1'b1) begin
      n++;
      if (n > 100) begin
        error_cnt++;
        report_and_stop();
      end
      @(posedge clock_in);
    end
  endtask : wait_hi
  task automatic ahb(input logic w, input logic [7:0] o, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, o};
    hwrite <= w;
    wait_hi();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_hi();
    r = hrdata;
  endtask : ahb
  // one link request through the host registers, then collect status and read data
  task automatic cmd(input logic [31:0] c, input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, HOST_ADDR_OFS, a, r);
    ahb(1'b1, HOST_WDATA_OFS, d, r);
    ahb(1'b1, HOST_CTRL_OFS, c, r);
    halt_seen = 1'b0;
    busy_cyc = 0;
    @(posedge clock_in);
    do begin
      ahb(1'b0, HOST_STATUS_OFS, 32'h0, r);
      halt_seen |= (halt === 1'b1);
      busy_cyc++;
      if (busy_cyc > 400) begin
        error_cnt++;
        report_and_stop();
      end
    end while (r[0] !== 1'b0);
    repeat (2) @(posedge clock_in);
    irq_seen = irq;
    ahb(1'b0, HOST_IRQ_STAT_OFS, 32'h0, stat);
    ahb(1'b0, HOST_RDATA_OFS, 32'h0, rd);
  endtask : cmd
  initial begin
    repeat (10) @(posedge clock_in);
    reset_in <= 1'b0;
    @(posedge clock_in);
    `CHK("hready", 1'b1, hready);
    `CHK("irq_rst", 1'b0, irq);
    ahb(1'b0, 8'h1c, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd);
    ahb(1'b1, HOST_IRQ_MASK_OFS, 32'h2, rd);
    cmd(WR, ra(CONFIG_OFS), 32'h2);
    `CHK("cfg_done", 32'h1, stat);
    cmd(RD, ra(CONFIG_OFS), 32'h0);
    `CHK("mode_rd", 32'h2, rd);
    cmd(WR, ra(ALL_ERASE_OFS), 32'h0);
    cmd(RD, ra(READY_OFS), 32'h0);
    `CHK("ready_busy", 1'b0, rd[0]);
    cmd(FE, 32'h50, 32'h0);
    `CHK("all_stall", 1'b1, busy_cyc > 80);
    cmd(RD, ra(READY_OFS), 32'h0);
    `CHK("ready_idle", 1'b1, rd[0]);
    cmd(RD, 32'h14, 32'h0);
    `CHK("all_flash", 32'hffff_ffff, rd);
    cmd(RD, UA, 32'h0);
    `CHK("all_user", 32'hffff_ffff, rd);
    cmd(RD, {FACT_PAGE, 12'h000}, 32'h0);
    `CHK("factory", FACT_WORD, rd);
    cmd(WR, ra(CONFIG_OFS), 32'h1);
    cmd(WR, 32'h4, 32'hf0f0_ff00);
    `CHK("irq_masked", 1'b0, irq_seen);
    cmd(RD, 32'h4, 32'h0);
    `CHK("word_1", 32'hf0f0_ff00, rd);
    cmd(WR, 32'h4, 32'h0ff0_0f0f);
    cmd(RD, 32'h4, 32'h0);
    `CHK("word_and", 32'h00f0_0f00, rd);
    cmd(WR, 32'h4, 32'h0);
    `CHK("third_wr", 32'h4, stat);
    cmd(RD, 32'h4, 32'h0);
    `CHK("word_kept", 32'h00f0_0f00, rd);
    cmd(WR, 32'h40, 32'h0000_1111);
    for (int i = 0; i < 3; i++) begin
      cmd(bad_c[i], bad_a[i], 32'h0);
      `CHK("fault", 32'h2, stat);
      `CHK("irq_fault", 1'b1, irq_seen);
    end
    `CHK("irq_clear", 1'b0, irq);
    cmd(RD, 32'h8, 32'h0);
    `CHK("fault_mem", 32'hffff_ffff, rd);
    cmd(32'h123, 32'hc, 32'h1234_5678);
    `CHK("halt_dbg", 1'b1, halt_seen);
    cmd(WR, UA, 32'h0000_00a5);
    `CHK("halt_none", 1'b0, halt_seen);
    `CHK("ucfg_old", 1'b1, ucfg !== 32'h0000_00a5);
    cmd(WR, UA, 32'h0000_00a5);
    cmd(WR, UA, 32'h0);
    `CHK("user_limit", 32'h4, stat);
    // mid-run reset: user area takes effect, mode back to read-only
    reset_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    `CHK("ucfg_new", 32'h0000_00a5, ucfg);
    cmd(WR, 32'h10, 32'h0);
    `CHK("ro_done", 32'h1, stat);
    cmd(RD, 32'h10, 32'h0);
    `CHK("ro_write", 32'hffff_ffff, rd);
    cmd(WR, ra(PAGE_ERASE_OFS), 32'h0);
    cmd(RD, 32'h4, 32'h0);
    `CHK("ro_erase", 32'h00f0_0f00, rd);
    cmd(WR, ra(CONFIG_OFS), 32'h3);
    `CHK("mode_3", 32'h4, stat);
    cmd(WR, ra(CONFIG_OFS), 32'h2);
    cmd(WR, ra(PAGE_ERASE_OFS), 32'h0);
    cmd(FE, 32'h50, 32'h0);
    `CHK("page_stall", 1'b1, busy_cyc > 50);
    cmd(RD, 32'h4, 32'h0);
    `CHK("page_ones", 32'hffff_ffff, rd);
    cmd(RD, 32'h40, 32'h0);
    `CHK("page_other", 32'h0000_1111, rd);
    cmd(WR, ra(USER_ERASE_OFS), 32'h0);
    cmd(FE, 32'h50, 32'h0);
    `CHK("user_stall", 1'b1, busy_cyc > 50);
    cmd(RD, UA, 32'h0);
    `CHK("user_ones", 32'hffff_ffff, rd);
    cmd(WR, ra(CONFIG_OFS), 32'h0);
    `CHK("hresp", 1'b0, hresp);
    report_and_stop();
  end
endmodule : flash_program_erase_ctrl_bench
`default_nettype wire
